// ===== verilog/phase2_map_pkg.sv
package phase2_map_pkg;

    // clock and slot timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int ASYNC_PERIOD_US = 228;
    localparam int SYNC_PERIOD_US = 500;
    localparam int ASYNC_PERIOD_CYCLES =
        (ASYNC_PERIOD_US * 1000) / CLK_PERIOD_NS;

    // frame shape
    localparam int FIELD_COUNT = 32;
    localparam logic [3:0] REPEAT_ASYNC = 4'h8;
    localparam logic [3:0] REPEAT_SYNC = 4'h4;

    // hard-coded nibbles
    localparam logic [3:0] PROTOCOL_REV_CODE = 4'h4;
    localparam logic [3:0] BLOCK_COUNT_HIGH = 4'h2;
    localparam logic [3:0] BLOCK_COUNT_LOW = 4'h0;
    localparam logic [3:0] SENSOR_TYPE_HIGH = 4'h0;
    localparam logic [3:0] SENSOR_TYPE_LOW = 4'h1;
    localparam logic [3:0] AXIS_CODE_0 = 4'h0;
    localparam logic [3:0] AXIS_CODE_1 = 4'h4;
    localparam logic [3:0] AXIS_CODE_2 = 4'h8;
    localparam logic [3:0] AXIS_CODE_3 = 4'hc;
    localparam logic [3:0] RANGE_CODE_60G = 4'h7;
    localparam logic [3:0] RANGE_CODE_120G = 4'h8;
    localparam logic [3:0] RANGE_CODE_240G = 4'h9;
    localparam logic [3:0] RANGE_CODE_480G = 4'ha;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;

    // register byte offsets
    localparam logic [4:0] CONTROL_OFFSET = 5'h00;
    localparam logic [4:0] MANUFACTURER_OFFSET = 5'h04;
    localparam logic [4:0] CONFIG_OFFSET = 5'h08;
    localparam logic [4:0] DATE_OFFSET = 5'h0c;
    localparam logic [4:0] SERIAL_OFFSET = 5'h10;
    localparam logic [4:0] REVISION_OFFSET = 5'h14;
    localparam logic [4:0] STATUS_OFFSET = 5'h18;

    // control field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_AXIS_LSB = 4;
    localparam int CTRL_RANGE_LSB = 6;

    // reset values
    localparam logic [7:0] MANUFACTURER_RESET = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h20;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [31:0] SERIAL_RESET = 32'h0000_0000;
    localparam logic [7:0] REVISION_RESET = 8'h00;

    typedef enum logic [1:0] {
        RANGE_60G = 2'h0,
        RANGE_120G = 2'h1,
        RANGE_240G = 2'h2,
        RANGE_480G = 2'h3
    } range_type;

    // programmed content of the frame
    typedef struct packed {
        logic ext_enable;
        logic [1:0] axis_dir;
        range_type range_sel;
        logic [7:0] manufacturer_code_field;
        logic [7:0] device_config_byte_one;
        logic [7:0] device_config_byte_two;
        logic [7:0] device_config_byte_six;
        logic [6:0] julian_year;
        logic [3:0] julian_month;
        logic [3:0] julian_day;
        logic [31:0] serial;
        logic [7:0] revision;
    } frame_cfg_type;

    // self-test results from the measurement path
    typedef struct packed {
        logic offset_valid;
        logic [9:0] offset_raw;
        logic avg_valid;
        logic [9:0] self_test_average;
    } self_test_type;

    // one transmission
    typedef struct packed {
        logic is_id;
        logic [3:0] nibble;
    } tx_word_type;

endpackage

// ===== verilog/phase2_nibble_map.sv
`timescale 1ns/1ps
module phase2_nibble_map
    import phase2_map_pkg::*;
(
    // frame position
    input wire logic [4:0] field,
    // content sources
    input wire frame_cfg_type cfg,
    input wire self_test_type st,
    // mapped nibbles
    output logic [3:0] id_nibble,
    output logic [3:0] data_nibble
);

    logic [3:0] off_n0;
    logic [3:0] off_n1;
    logic [1:0] off_hi;
    logic [1:0] avg_lo;
    logic [3:0] avg_n1;
    logic [3:0] avg_n2;

    // identifier wraps every sixteen fields
    assign id_nibble = field[3:0];

    // unfinished results go out as zero
    assign off_n0 = st.offset_valid ? st.offset_raw[3:0] : ZERO_NIBBLE; // [RULE11]
    assign off_n1 = st.offset_valid ? st.offset_raw[7:4] : ZERO_NIBBLE; // [RULE11]
    assign off_hi = st.offset_valid ? st.offset_raw[9:8] : 2'h0; // [RULE11]
    assign avg_lo = st.avg_valid ? st.self_test_average[1:0] : 2'h0; // [RULE11]
    assign avg_n1 = st.avg_valid ? st.self_test_average[5:2] : ZERO_NIBBLE;
    assign avg_n2 = st.avg_valid ? st.self_test_average[9:6] : ZERO_NIBBLE;

    // data nibble per field
    always_comb begin
        data_nibble = ZERO_NIBBLE;
        unique case (field)
            5'd0: data_nibble = PROTOCOL_REV_CODE; // [RULE1]
            5'd1: data_nibble = BLOCK_COUNT_HIGH; // [RULE2]
            5'd2: data_nibble = BLOCK_COUNT_LOW; // [RULE2]
            5'd3: data_nibble = cfg.manufacturer_code_field[7:4]; // [RULE3]
            5'd4: data_nibble = cfg.manufacturer_code_field[3:0]; // [RULE3]
            5'd5: data_nibble = SENSOR_TYPE_HIGH; // [RULE4]
            5'd6: data_nibble = SENSOR_TYPE_LOW; // [RULE4]
            5'd7: begin
                unique case (cfg.axis_dir) // [RULE5]
                    2'h0: data_nibble = AXIS_CODE_0;
                    2'h1: data_nibble = AXIS_CODE_1;
                    2'h2: data_nibble = AXIS_CODE_2;
                    2'h3: data_nibble = AXIS_CODE_3;
                endcase
            end
            5'd8: begin
                unique case (cfg.range_sel) // [RULE6]
                    RANGE_60G: data_nibble = RANGE_CODE_60G;
                    RANGE_120G: data_nibble = RANGE_CODE_120G;
                    RANGE_240G: data_nibble = RANGE_CODE_240G;
                    RANGE_480G: data_nibble = RANGE_CODE_480G;
                endcase
            end
            5'd9: data_nibble = cfg.device_config_byte_two[7:4]; // [RULE13]
            5'd10: data_nibble = cfg.device_config_byte_two[3:0]; // [RULE13]
            5'd11: data_nibble = cfg.revision[7:4]; // [RULE13]
            5'd12: data_nibble = cfg.revision[3:0]; // [RULE13]
            5'd13: data_nibble = cfg.device_config_byte_six[3:0]; // [RULE13]
            5'd14: data_nibble = cfg.julian_year[6:3]; // [RULE7]
            5'd15: data_nibble = {cfg.julian_year[2:0],
                                  cfg.julian_month[3]}; // [RULE7]
            5'd16: data_nibble = {cfg.julian_month[2:0],
                                  cfg.julian_day[1]}; // [RULE7]
            5'd17: data_nibble = cfg.julian_day[3:0]; // [RULE7]
            5'd18: data_nibble = cfg.serial[7:4]; // [RULE12]
            5'd19: data_nibble = cfg.serial[3:0]; // [RULE12]
            5'd20: data_nibble = cfg.serial[15:12]; // [RULE12]
            5'd21: data_nibble = cfg.serial[11:8]; // [RULE12]
            5'd22: data_nibble = cfg.serial[23:20]; // [RULE12]
            5'd23: data_nibble = cfg.serial[19:16]; // [RULE12]
            5'd24: data_nibble = cfg.serial[31:28]; // [RULE12]
            5'd25: data_nibble = cfg.serial[27:24]; // [RULE12]
            5'd26: data_nibble = cfg.ext_enable ? off_n0 : ZERO_NIBBLE; // [RULE8] [RULE9]
            5'd27: data_nibble = cfg.ext_enable ? off_n1 : ZERO_NIBBLE; // [RULE8] [RULE9]
            5'd28: data_nibble = cfg.ext_enable ?
                {avg_lo, off_hi} : ZERO_NIBBLE; // [RULE8] [RULE9]
            5'd29: data_nibble = cfg.ext_enable ? avg_n1 : ZERO_NIBBLE; // [RULE8] [RULE9]
            5'd30: data_nibble = cfg.ext_enable ? avg_n2 : ZERO_NIBBLE; // [RULE8] [RULE9]
            5'd31: data_nibble = cfg.ext_enable ?
                cfg.device_config_byte_one[7:4] : ZERO_NIBBLE; // [RULE10] [RULE9]
        endcase
    end

endmodule

// ===== verilog/phase2_sequencer.sv
`timescale 1ns/1ps
module phase2_sequencer
    import phase2_map_pkg::*;
#(
    parameter int FIELDS = FIELD_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic slot,
    input wire logic [3:0] repeat_count,
    // progress
    output logic fire,
    output logic fire_is_id,
    output logic [4:0] field,
    output logic [3:0] rep,
    output logic active,
    output logic done
);

    if (FIELDS < 1 || FIELDS > 32) begin : g_check
        $error("phase2_sequencer: FIELDS must be 1 to 32");
    end

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ID = 4'b0010,
        S_DATA = 4'b0100,
        S_DONE = 4'b1000
    } seq_state_type;

    localparam logic [4:0] LAST_FIELD = 5'(FIELDS - 1);

    seq_state_type state_q;
    logic [4:0] field_q;
    logic [3:0] rep_q;
    logic last_rep;

    assign last_rep = (rep_q == repeat_count - 4'h1);
    assign fire = slot && (state_q == S_ID || state_q == S_DATA);
    assign fire_is_id = (state_q == S_ID); // [RULE14]
    assign field = field_q;
    assign rep = rep_q;
    assign active = (state_q == S_ID || state_q == S_DATA);
    assign done = (state_q == S_DONE);

    // identifier then data, k times per field, then next field
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            field_q <= 5'h00;
            rep_q <= 4'h0;
        end else if (start) begin
            state_q <= S_ID;
            field_q <= 5'h00;
            rep_q <= 4'h0;
        end else if (slot) begin
            unique case (state_q)
                S_IDLE: state_q <= S_IDLE;
                S_ID: state_q <= S_DATA; // [RULE14]
                S_DATA: begin
                    if (!last_rep) begin
                        rep_q <= rep_q + 4'h1; // [RULE14]
                        state_q <= S_ID;
                    end else if (field_q == LAST_FIELD) begin
                        rep_q <= 4'h0;
                        state_q <= S_DONE;
                    end else begin
                        rep_q <= 4'h0;
                        field_q <= field_q + 5'h01;
                        state_q <= S_ID;
                    end
                end
                S_DONE: state_q <= S_DONE;
            endcase
        end
    end

endmodule

// ===== verilog/init_phase2_ten_bit_data_map.sv
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Field one, identifier 0000, always carries protocol revision 0100.
// [RULE2] Fields two and three carry the block count 32 as 0010 then 0000.
// [RULE3] Fields four and five carry the programmed manufacturer code.
// [RULE4] Fields six and seven carry sensor type high-g as 0000 then 0001.
// [RULE5] Field eight maps the axis select 00,01,10,11 to 0000,0100,1000,1100.
// [RULE6] Field nine gives the range code 0111,1000,1001,1010 for 60g to 480g.
// [RULE7] Fields fifteen to eighteen carry the Julian date bits in order; field seventeen ends with day bit 1, not day bit 3.
// [RULE8] Fields 27 to 31 carry raw offset and self-test average, mixed at 29.
// [RULE9] With extended data disabled, fields 27 to 32 carry 0000.
// [RULE10] Field 32 carries the upper nibble of configuration byte one.
// [RULE11] Offset or average not yet finished when due is sent as zeros.
// [RULE12] Fields 19 to 26 carry serial bytes zero to three, high nibble first.
// [RULE13] Fields 10 to 14 carry config byte two, revision, config byte six.
// [RULE14] Each field goes as identifier then data, that pair repeated k times.
// [RULE15] k is 8 in asynchronous mode at 228 us and 4 in sync mode at 500 us.
module init_phase2_ten_bit_data_map
    import phase2_map_pkg::*;
#(
    parameter int ASYNC_CYCLES = ASYNC_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // avalon-mm slave
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // sync pulse pin
    input wire logic SYNC_PULSE,
    // self-test results, same clock
    input wire logic OFFSET_VALID,
    input wire logic [9:0] OFFSET_RAW,
    input wire logic AVG_VALID,
    input wire logic [9:0] SELF_TEST_AVERAGE,
    // transmitter side
    output logic TX_STROBE,
    output logic TX_IS_ID,
    output logic [3:0] TX_NIBBLE,
    output logic PHASE2_ACTIVE,
    output logic PHASE2_DONE
);

    if (ASYNC_CYCLES < 2 || ASYNC_CYCLES > 65535) begin : g_check
        $error("init_phase2_ten_bit_data_map: ASYNC_CYCLES out of range");
    end

    // byte-lane merge of a write into a word
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] lanes
    );
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // programmable content
    logic ext_q;
    logic sync_mode_q;
    logic [1:0] axis_q;
    logic [1:0] range_q;
    logic [7:0] mfg_q;
    logic [7:0] cfg_one_q;
    logic [7:0] cfg_two_q;
    logic [7:0] cfg_six_q;
    logic [6:0] year_q;
    logic [3:0] month_q;
    logic [3:0] day_q;
    logic [31:0] serial_q;
    logic [7:0] revision_q;
    logic start_q;

    // bus handshake
    logic wait_q;
    logic [31:0] rdata_q;
    logic take_write;
    logic [31:0] ctrl_word;
    logic [31:0] cfg_word;
    logic [31:0] date_word;
    logic [31:0] status_word;
    logic [31:0] ctrl_new;
    logic [31:0] cfg_new;
    logic [31:0] date_new;
    logic [31:0] serial_new;
    logic [31:0] mfg_new;
    logic [31:0] rev_new;

    // slot timing
    logic sync_meta_q;
    logic sync_s_q;
    logic sync_prev_q;
    logic [15:0] timer_q;
    logic timer_wrap;
    logic slot;

    // sequencer and map
    frame_cfg_type cfg;
    self_test_type st;
    logic fire;
    logic fire_is_id;
    logic [4:0] field;
    logic [3:0] rep;
    logic seq_active;
    logic seq_done;
    logic [3:0] id_nibble;
    logic [3:0] data_nibble;
    logic [3:0] repeat_count;
    tx_word_type word_q;
    logic strobe_q;
    logic active_q;
    logic done_q;

    localparam logic [15:0] TIMER_LAST = 16'(ASYNC_CYCLES - 1);

    // register images
    assign ctrl_word = {24'h0, range_q, axis_q, 1'b0, 1'b0,
                        sync_mode_q, ext_q};
    assign cfg_word = {8'h0, cfg_six_q, cfg_two_q, cfg_one_q};
    assign date_word = {12'h0, day_q, 4'h0, month_q, 1'b0, year_q};
    assign status_word = {13'h0, rep[2:0], 3'h0, field,
                          6'h0, seq_done, seq_active};
    assign ctrl_new = merge_lanes(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign cfg_new = merge_lanes(cfg_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign date_new = merge_lanes(date_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign serial_new = merge_lanes(serial_q, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign mfg_new = merge_lanes({24'h0, mfg_q}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);
    assign rev_new = merge_lanes({24'h0, revision_q}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);

    // write commits on the edge where waitrequest is seen low
    assign take_write = AVS_WRITE && !wait_q;

    // one wait state, then a one-cycle acknowledge
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(AVS_READ || AVS_WRITE) || !wait_q;
        end
    end

    // read data captured with the acknowledge
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 32'h0000_0000;
        end else if (AVS_READ && wait_q) begin
            unique case (AVS_ADDRESS)
                CONTROL_OFFSET: rdata_q <= ctrl_word;
                MANUFACTURER_OFFSET: rdata_q <= {24'h0, mfg_q};
                CONFIG_OFFSET: rdata_q <= cfg_word;
                DATE_OFFSET: rdata_q <= date_word;
                SERIAL_OFFSET: rdata_q <= serial_q;
                REVISION_OFFSET: rdata_q <= {24'h0, revision_q};
                STATUS_OFFSET: rdata_q <= status_word;
                default: rdata_q <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // control register and start pulse
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ext_q <= 1'b0;
            sync_mode_q <= 1'b0;
            axis_q <= 2'h0;
            range_q <= 2'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (take_write && AVS_ADDRESS == CONTROL_OFFSET) begin
                ext_q <= ctrl_new[CTRL_EXT_BIT];
                sync_mode_q <= ctrl_new[CTRL_SYNC_BIT];
                axis_q <= ctrl_new[CTRL_AXIS_LSB +: 2];
                range_q <= ctrl_new[CTRL_RANGE_LSB +: 2];
                start_q <= AVS_BYTEENABLE[0] &&
                           AVS_WRITEDATA[CTRL_START_BIT];
            end
        end
    end

    // content registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mfg_q <= MANUFACTURER_RESET;
            cfg_one_q <= CONFIG_ONE_RESET;
            cfg_two_q <= CONFIG_RESET;
            cfg_six_q <= CONFIG_RESET;
            year_q <= 7'h00;
            month_q <= 4'h0;
            day_q <= 4'h0;
            serial_q <= SERIAL_RESET;
            revision_q <= REVISION_RESET;
        end else if (take_write) begin
            unique case (AVS_ADDRESS)
                MANUFACTURER_OFFSET: mfg_q <= mfg_new[7:0];
                CONFIG_OFFSET: begin
                    cfg_one_q <= cfg_new[7:0];
                    cfg_two_q <= cfg_new[15:8];
                    cfg_six_q <= cfg_new[23:16];
                end
                DATE_OFFSET: begin
                    year_q <= date_new[6:0];
                    month_q <= date_new[11:8];
                    day_q <= date_new[19:16];
                end
                SERIAL_OFFSET: serial_q <= serial_new;
                REVISION_OFFSET: revision_q <= rev_new[7:0];
                default: ; // control handled apart, others ignored
            endcase
        end
    end

    // sync pulse pin through two flops, then edge detect
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sync_meta_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= SYNC_PULSE;
            sync_s_q <= sync_meta_q;
            sync_prev_q <= sync_s_q;
        end
    end

    // free-running slot timer for asynchronous mode
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            timer_q <= 16'h0000;
        end else if (start_q || timer_wrap) begin
            timer_q <= 16'h0000;
        end else begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    assign timer_wrap = (timer_q == TIMER_LAST);
    assign slot = sync_mode_q ? (sync_s_q && !sync_prev_q) : timer_wrap;
    assign repeat_count = sync_mode_q ? REPEAT_SYNC : REPEAT_ASYNC; // [RULE15]

    assign cfg = '{
        ext_enable: ext_q,
        axis_dir: axis_q,
        range_sel: range_type'(range_q),
        manufacturer_code_field: mfg_q,
        device_config_byte_one: cfg_one_q,
        device_config_byte_two: cfg_two_q,
        device_config_byte_six: cfg_six_q,
        julian_year: year_q,
        julian_month: month_q,
        julian_day: day_q,
        serial: serial_q,
        revision: revision_q
    };

    // results count only once their phase is complete
    assign st = '{
        offset_valid: OFFSET_VALID, // [RULE11]
        offset_raw: OFFSET_RAW,
        avg_valid: AVG_VALID, // [RULE11]
        self_test_average: SELF_TEST_AVERAGE
    };

    phase2_sequencer #(
        .FIELDS(FIELD_COUNT)
    ) u_seq (
        .clk(CLK),
        .nrst(NRST),
        .start(start_q),
        .slot(slot),
        .repeat_count(repeat_count),
        .fire(fire),
        .fire_is_id(fire_is_id),
        .field(field),
        .rep(rep),
        .active(seq_active),
        .done(seq_done)
    );

    phase2_nibble_map u_map (
        .field(field),
        .cfg(cfg),
        .st(st),
        .id_nibble(id_nibble),
        .data_nibble(data_nibble)
    );

    // transmit word registered on each slot while the sequencer is active
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            word_q <= '{is_id: 1'b0, nibble: 4'h0};
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= fire;
            if (fire) begin
                word_q.is_id <= fire_is_id; // [RULE14]
                word_q.nibble <= fire_is_id ? id_nibble : data_nibble;
            end
        end
    end

    // phase status flags
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            active_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            active_q <= seq_active;
            done_q <= seq_done;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign TX_STROBE = strobe_q;
    assign TX_IS_ID = word_q.is_id;
    assign TX_NIBBLE = word_q.nibble;
    assign PHASE2_ACTIVE = active_q;
    assign PHASE2_DONE = done_q;

endmodule

// ===== bench/phase2_map_props.sv
`timescale 1ns/1ps
module phase2_map_props (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // register bus
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // transmit stream
    input wire logic TX_STROBE,
    input wire logic TX_IS_ID,
    input wire logic [3:0] TX_NIBBLE,
    input wire logic PHASE2_ACTIVE
);
    logic kind_q;
    logic [3:0] id_q, rep_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // last strobe kind, identifier and its repeats
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            kind_q <= 1'b0;
            id_q <= 4'h0;
            rep_q <= 4'h0;
        end else if (TX_STROBE) begin
            kind_q <= TX_IS_ID;
            if (TX_IS_ID) begin
                id_q <= TX_NIBBLE;
                rep_q <= (TX_NIBBLE == id_q) ? rep_q + 4'h1 : 4'h1;
            end
        end
    end
    // request not yet answered
    sequence s_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    a_wait_answer: assert property (s_taken |=> !AVS_WAITREQUEST)
        else $error("no answer");
    a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("long acknowledge");
    a_rdata_hold: assert property
        (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data moved");
    a_strobe_gap: assert property (TX_STROBE |=> !TX_STROBE [*2])
        else $error("strobe gap");
    a_pair_alt: assert property (TX_STROBE |-> TX_IS_ID != kind_q)
        else $error("no alternation");
    a_id_step: assert property (TX_STROBE && TX_IS_ID |->
        TX_NIBBLE == id_q || TX_NIBBLE == id_q + 4'h1)
        else $error("id skipped");
    a_rep_count: assert property (TX_STROBE && TX_IS_ID &&
        TX_NIBBLE != id_q |-> rep_q == 4'h4 || rep_q == 4'h8)
        else $error("repeat count");
    a_idle_quiet: assert property
        (!PHASE2_ACTIVE && !$past(PHASE2_ACTIVE) |-> !TX_STROBE)
        else $error("idle strobe");
endmodule
bind init_phase2_ten_bit_data_map phase2_map_props props_u (
    .CLK(CLK), .NRST(NRST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TX_STROBE(TX_STROBE), .TX_IS_ID(TX_IS_ID), .TX_NIBBLE(TX_NIBBLE),
    .PHASE2_ACTIVE(PHASE2_ACTIVE));

// ===== bench/ecu_rx_model.sv
`timescale 1ns/1ps
module ecu_rx_model (
    // clock and control
    input wire logic clk,
    input wire logic clr,
    input wire logic sync_en,
    input wire logic [3:0] k,
    // transmit stream
    input wire logic strobe,
    input wire logic is_id,
    input wire logic [3:0] nibble,
    // sync pin and results
    output logic sync_pulse,
    output int count,
    output int errs,
    output logic [3:0] data [32]
);
    int tick = 0, f;
    initial sync_pulse = 1'b0;
    // sync pulse every ten cycles
    always @(posedge clk) begin
        tick <= (tick + 1) % 10;
        sync_pulse <= sync_en && tick < 2;
    end
    // capture data nibbles, check order and repeats
    always @(posedge clk) begin
        f = count / (2 * k);
        if (clr) begin
            count <= 0;
            errs <= 0;
        end else if (strobe) begin
            count <= count + 1;
            if (is_id !== (count % 2 == 0) || f > 31) errs <= errs + 1;
            else if (is_id && nibble !== f[3:0]) errs <= errs + 1;
            else if (!is_id) data[f] <= nibble;
        end
    end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic CLK = 1'b0, NRST = 1'b0, rd = 1'b0, wr = 1'b0, vld = 1'b0;
    logic sync_en = 1'b0, clr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [3:0] kk = 4'h8;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic waitreq, sync_pin, stb, is_id, act, done;
    logic [3:0] nib, e;
    logic [3:0] d [32];
    int rx_count, rx_errs;
    int n_fail = 0, tests_run = 0;
    always #20 CLK = ~CLK;
    init_phase2_ten_bit_data_map #(.ASYNC_CYCLES(8)) dut_u (
        .CLK(CLK), .NRST(NRST), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .SYNC_PULSE(sync_pin), .OFFSET_VALID(vld), .OFFSET_RAW(10'h2d6),
        .AVG_VALID(vld), .SELF_TEST_AVERAGE(10'h39b), .TX_STROBE(stb),
        .TX_IS_ID(is_id), .TX_NIBBLE(nib), .PHASE2_ACTIVE(act),
        .PHASE2_DONE(done));
    ecu_rx_model rx_u (.clk(CLK), .clr(clr), .sync_en(sync_en), .k(kk),
        .strobe(stb), .is_id(is_id), .nibble(nib), .sync_pulse(sync_pin),
        .count(rx_count), .errs(rx_errs), .data(d));
    // counted comparison
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
        tests_run++;
        if (g !== ex) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // one access, held until waitrequest is seen low
    task automatic bus(logic w, logic [4:0] a, logic [31:0] wd);
        int n = 0;
        @(posedge CLK);
        addr <= a;
        wdata <= wd;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge CLK);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) chk("waitrequest", 0, 1);
    endtask
    task automatic rchk(string nm, logic [4:0] a, logic [31:0] ex);
        bus(1'b0, a, 32'h0);
        chk(nm, ex, q);
    endtask
    // expected data nibble of field f, field 0 leftmost
    function automatic logic [3:0] exp_nib(int f, logic [1:0] ax,
        logic [1:0] rg, logic ex, logic v);
        logic [127:0] t;
        t = 128'h4205_a010_0b7d_2cb7_3aef_cdab_896d_e6e6;
        t[92 +: 8] = {ax, 2'b00, 4'h7 + rg};
        return (f > 25 && (!ex || (!v && f < 31))) ? 4'h0
            : t[124 - f * 4 +: 4];
    endfunction
    task automatic end_sim();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (40000) @(posedge CLK);
        n_fail++;
        end_sim();
    end
    // registers, then four frames
    initial begin
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        rchk("control", 5'h00, 32'h0);
        rchk("config", 5'h08, 32'h20);
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rchk("unmapped", 5'h1c, 32'h0);
        bus(1'b1, 5'h04, 32'h5a);
        bus(1'b1, 5'h08, 32'h3c_b765);
        bus(1'b1, 5'h0c, 32'h0a_095b);
        bus(1'b1, 5'h10, 32'h89ab_cdef);
        bus(1'b1, 5'h14, 32'hd2);
        rchk("serial", 5'h10, 32'h89ab_cdef);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            vld <= i < 2;
            sync_en <= i[0];
            kk <= i[0] ? 4'h4 : 4'h8;
            clr <= 1'b1;
            bus(1'b1, 5'h00, {2'(3 - i), 2'(i), 2'b01, i[0], i != 1});
            clr <= 1'b0;
            repeat (3) @(posedge CLK);
            while (done !== 1'b1) @(posedge CLK);
            chk("strobes", 64 * kk, rx_count);
            chk("order", 0, rx_errs);
            rchk("status", 5'h18, 32'h1f02);
            for (int f = 0; f < 32; f++) begin
                e = exp_nib(f, 2'(i), 2'(3 - i), i != 1, i < 2);
                chk("nib", e, d[f]);
            end
            $display("run %0d done", i);
        end
        end_sim();
    end
endmodule
